/* File: rtl/adcfl_seq.sv */
module adcfl_seq (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_start,
  input wire logic i_sleep_sel,
  // conversion core
  input wire logic i_eoc,
  input wire logic i_seq_end,
  output logic o_start,
  // state
  output logic o_busy,
  output logic o_sleep
);
  import adcfl_pkg::*;

  adcfl_seq_e state_r;
  adcfl_seq_e state_nxt;
  logic start_r;

  // sleep only entered at the end of a conversion
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ADCFL_S_IDLE:
        if (i_start)
          state_nxt = ADCFL_S_CONV;
      ADCFL_S_CONV:
        if (i_eoc && i_seq_end)
          state_nxt = i_sleep_sel ? ADCFL_S_SLEEP : ADCFL_S_IDLE;
      ADCFL_S_SLEEP:
        if (i_start)
          state_nxt = ADCFL_S_CONV;
        else if (!i_sleep_sel)
          state_nxt = ADCFL_S_IDLE;
      default:
        state_nxt = ADCFL_S_IDLE;
    endcase
  end

  // state and start pulse to the core
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_r <= ADCFL_S_IDLE;
      start_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      start_r <= i_start && (state_r != ADCFL_S_CONV);
    end
  end

  assign o_start = start_r;
  assign o_busy = (state_r == ADCFL_S_CONV);
  assign o_sleep = (state_r == ADCFL_S_SLEEP);
endmodule

/* File: rtl/adcfl_top.sv */
// Notes on behaviour
// - data ready cleared only by last result read
// - data ready set only when data stored
// - completion with flag set, other read: ready set
// - disable elsewhere never blocks data ready
// - status read still updates general overrun
// - completion while data ready gives general overrun
// - general overrun set despite other channel read
// - disable elsewhere: both overrun flags still set
// - status read clears channel overrun unless set same cycle
// - channel read clears its end flag, last read clears all end flags, unless set same cycle
// - disabled channel never raises end flag
// - channel read clears only its own flag
// - sleep entered at end of next conversion
//
// The Wishbone slave port and the register addresses were left to the implementer.
module adcfl_top #(
  parameter int unsigned NCH = adcfl_pkg::ADCFL_NCH,
  parameter int unsigned DW = adcfl_pkg::ADCFL_DW
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_SRST,
  // wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [adcfl_pkg::ADCFL_AW-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // conversion core
  input wire logic I_EOC,
  input wire logic [$clog2(NCH)-1:0] I_EOC_CH,
  input wire logic [DW-1:0] I_EOC_DATA,
  input wire logic I_SEQ_END,
  output logic O_START,
  output logic [NCH-1:0] O_CH_EN,
  output logic O_SLEEP,
  // interrupt
  output logic O_IRQ
);
  import adcfl_pkg::*;

  localparam int unsigned CHW = $clog2(NCH);
  localparam int unsigned AW = ADCFL_AW;

  adcfl_acc_if #(.AW(AW)) acc_b ();

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [NCH-1:0] ch_bit(input logic [CHW-1:0] ch);
    ch_bit = '0;
    ch_bit[ch] = 1'b1;
  endfunction

  logic wr;
  logic rd;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_chen;
  logic wr_chdis;
  logic wr_iclr;
  logic wr_ien;
  logic rd_sr;
  logic rd_last;
  logic rd_cdr;
  logic hit_cdr;
  logic [AW-1:0] cdr_off;
  logic [CHW-1:0] cdr_idx;
  logic [31:0] wd;

  // state
  logic [NCH-1:0] chen_r;
  logic [NCH-1:0] chen_nxt;
  logic [NCH-1:0] eoc_r;
  logic [NCH-1:0] eoc_nxt;
  logic [NCH-1:0] ovr_r;
  logic [NCH-1:0] ovr_nxt;
  logic data_ready_flag_r;
  logic data_ready_flag_nxt;
  logic govr_r;
  logic govr_nxt;
  logic sleep_sel_r;
  logic [ADCFL_IRQ_W-1:0] ist_r;
  logic [ADCFL_IRQ_W-1:0] ist_nxt;
  logic [ADCFL_IRQ_W-1:0] ist_set;
  logic [ADCFL_IRQ_W-1:0] ien_r;
  logic [DW-1:0] cdr_r [NCH];
  logic [DW-1:0] last_r;
  logic [CHW-1:0] last_ch_r;

  // events
  logic store;
  logic [NCH-1:0] set_m;
  logic [NCH-1:0] clr_m;
  logic [NCH-1:0] ovr_set_m;
  logic govr_set;
  logic start_cmd;
  logic busy;

  // ****************************************
  // bus slave and sequencer
  // ****************************************
  adcfl_wbs u_wbs (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_cyc(I_WB_CYC),
    .i_stb(I_WB_STB),
    .i_we(I_WB_WE),
    .i_adr(I_WB_ADR),
    .i_sel(I_WB_SEL),
    .i_dat(I_WB_DAT),
    .o_dat(O_WB_DAT),
    .o_ack(O_WB_ACK),
    .acc_p(acc_b.slv)
  );

  adcfl_seq u_seq (
    .i_clk(I_REF_CLK),
    .i_srst(I_SRST),
    .i_start(start_cmd),
    .i_sleep_sel(sleep_sel_r),
    .i_eoc(I_EOC),
    .i_seq_end(I_SEQ_END),
    .o_start(O_START),
    .o_busy(busy),
    .o_sleep(O_SLEEP)
  );

  // access decode
  assign wr = acc_b.acc & acc_b.we;
  assign rd = acc_b.acc & ~acc_b.we;
  assign wd = acc_b.wdat & acc_b.wmask;
  assign wr_ctrl = wr && (acc_b.adr == ADCFL_OFS_CTRL);
  assign wr_mode = wr && (acc_b.adr == ADCFL_OFS_MODE);
  assign wr_chen = wr && (acc_b.adr == ADCFL_OFS_CHEN);
  assign wr_chdis = wr && (acc_b.adr == ADCFL_OFS_CHDIS);
  assign wr_iclr = wr && (acc_b.adr == ADCFL_OFS_ICLR);
  assign wr_ien = wr && (acc_b.adr == ADCFL_OFS_IEN);
  assign rd_sr = rd && (acc_b.adr == ADCFL_OFS_STAT);
  assign rd_last = rd && (acc_b.adr == ADCFL_OFS_LAST);
  assign cdr_off = acc_b.adr - ADCFL_OFS_CDR0;
  assign cdr_idx = cdr_off[CHW+1:2];
  assign hit_cdr = (acc_b.adr >= ADCFL_OFS_CDR0) && (cdr_off < AW'(4 * NCH)) && (cdr_off[1:0] == 2'b00);
  assign rd_cdr = rd && hit_cdr;
  assign start_cmd = wr_ctrl && wd[ADCFL_CTRL_START];

  // ****************************************
  // flag update
  // ****************************************
  always_comb
  begin
    store = I_EOC && chen_r[I_EOC_CH];
    set_m = store ? ch_bit(I_EOC_CH) : '0;
    clr_m = rd_last ? '1 : (rd_cdr ? ch_bit(cdr_idx) : '0);
    eoc_nxt = set_m | (eoc_r & ~clr_m);
    ovr_set_m = set_m & eoc_r;
    ovr_nxt = ovr_set_m | (rd_sr ? '0 : ovr_r);
    data_ready_flag_nxt = store | (data_ready_flag_r & ~rd_last);
    govr_set = store & data_ready_flag_r;
    govr_nxt = govr_set | (govr_r & ~rd_sr);
    chen_nxt = chen_r;
    if (wr_chen)
      chen_nxt = chen_nxt | wd[NCH-1:0];
    if (wr_chdis)
      chen_nxt = chen_nxt & ~wd[NCH-1:0];
  end

  // status flags
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      eoc_r <= '0;
      ovr_r <= '0;
      data_ready_flag_r <= 1'b0;
      govr_r <= 1'b0;
    end
    else
    begin
      eoc_r <= eoc_nxt;
      ovr_r <= ovr_nxt;
      data_ready_flag_r <= data_ready_flag_nxt;
      govr_r <= govr_nxt;
    end
  end

  // channel enables and sleep selection
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      chen_r <= '0;
      sleep_sel_r <= ADCFL_RST_SLEEP;
    end
    else
    begin
      chen_r <= chen_nxt;
      if (wr_mode && acc_b.wmask[ADCFL_MODE_SLEEP])
        sleep_sel_r <= acc_b.wdat[ADCFL_MODE_SLEEP];
    end
  end

  // result storage, only for enabled channels
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      for (int i = 0; i < NCH; i++)
        cdr_r[i] <= '0;
      last_r <= '0;
      last_ch_r <= '0;
    end
    else if (store)
    begin
      cdr_r[I_EOC_CH] <= I_EOC_DATA;
      last_r <= I_EOC_DATA;
      last_ch_r <= I_EOC_CH;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  always_comb
  begin
    ist_set = '0;
    ist_set[ADCFL_IRQ_EOC] = store;
    ist_set[ADCFL_IRQ_DATA_READY_FLAG] = store & ~data_ready_flag_r;
    ist_set[ADCFL_IRQ_OVR] = |ovr_set_m;
    ist_set[ADCFL_IRQ_GOVR] = govr_set;
    ist_nxt = ist_set | (ist_r & ~(wr_iclr ? wd[ADCFL_IRQ_W-1:0] : '0));
  end

  // sticky status and enable
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SRST)
    begin
      ist_r <= '0;
      ien_r <= ADCFL_RST_IEN;
    end
    else
    begin
      ist_r <= ist_nxt;
      if (wr_ien)
        ien_r <= (ien_r & ~acc_b.wmask[ADCFL_IRQ_W-1:0]) | wd[ADCFL_IRQ_W-1:0];
    end
  end

  assign O_IRQ = |(ist_r & ien_r);
  assign O_CH_EN = chen_r;

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    acc_b.rdat = 32'h0000_0000;
    case (acc_b.adr)
      ADCFL_OFS_MODE:
        acc_b.rdat[ADCFL_MODE_SLEEP] = sleep_sel_r;
      ADCFL_OFS_CHSR:
        acc_b.rdat[NCH-1:0] = chen_r;
      ADCFL_OFS_STAT:
      begin
        acc_b.rdat[NCH-1:0] = eoc_r;
        acc_b.rdat[ADCFL_STAT_OVR_LSB +: NCH] = ovr_r;
        acc_b.rdat[ADCFL_STAT_DATA_READY_FLAG] = data_ready_flag_r;
        acc_b.rdat[ADCFL_STAT_GOVR] = govr_r;
        acc_b.rdat[ADCFL_STAT_BUSY] = busy;
        acc_b.rdat[ADCFL_STAT_SLEEP] = O_SLEEP;
      end
      ADCFL_OFS_LAST:
      begin
        acc_b.rdat[DW-1:0] = last_r;
        acc_b.rdat[ADCFL_LAST_CH_LSB +: CHW] = last_ch_r;
      end
      ADCFL_OFS_IST:
        acc_b.rdat[ADCFL_IRQ_W-1:0] = ist_r;
      ADCFL_OFS_IEN:
        acc_b.rdat[ADCFL_IRQ_W-1:0] = ien_r;
      default:
        if (hit_cdr)
          acc_b.rdat[DW-1:0] = cdr_r[cdr_idx];
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_SRST);

  sequence conv_end_s;
    busy && I_EOC && I_SEQ_END && sleep_sel_r && !start_cmd;
  endsequence

  sequence idle_s;
    !busy && !O_SLEEP && !start_cmd;
  endsequence

  data_ready_flag_hold_a: assert property (data_ready_flag_r && !rd_last |=> data_ready_flag_r)
    else $error("data ready dropped without last read");

  data_ready_flag_only_a: assert property (!store && !data_ready_flag_r |=> !data_ready_flag_r)
    else $error("data ready set without stored data");

  data_ready_flag_cdr_a: assert property (store && eoc_r[I_EOC_CH] && rd_cdr |=> data_ready_flag_r && eoc_r[$past(I_EOC_CH)])
    else $error("data ready skipped on channel read");

  data_ready_flag_dis_a: assert property (store && wr_chdis |=> data_ready_flag_r && (last_r == $past(I_EOC_DATA)))
    else $error("data ready skipped on disable");

  govr_upd_a: assert property (rd_sr && I_EOC |=> govr_r == $past(store && data_ready_flag_r))
    else $error("general overrun not updated on status read");

  govr_set_a: assert property (store && data_ready_flag_r |=> govr_r ##1 (govr_r || $past(rd_sr)))
    else $error("general overrun not raised");

  govr_cdr_a: assert property (store && eoc_r[I_EOC_CH] && data_ready_flag_r && rd_cdr |=> govr_r)
    else $error("general overrun missed on channel read");

  ovr_dis_a: assert property (store && eoc_r[I_EOC_CH] && data_ready_flag_r && wr_chdis
    |=> govr_r && ovr_r[$past(I_EOC_CH)])
    else $error("overrun flags missed on disable");

  ovr_clr_a: assert property (rd_sr && store && !eoc_r[I_EOC_CH] |=> !ovr_r[$past(I_EOC_CH)])
    else $error("channel overrun not cleared by status read");

  eoc_last_a: assert property (rd_last && !I_EOC |=> eoc_r == '0)
    else $error("end flags not cleared by last read");

  eoc_dis_a: assert property (I_EOC && !chen_r[I_EOC_CH] && !eoc_r[I_EOC_CH]
    |=> !eoc_r[$past(I_EOC_CH)])
    else $error("end flag raised on disabled channel");

  eoc_only_a: assert property (rd_cdr && !store
    |=> (eoc_r ^ $past(eoc_r)) == ($past(eoc_r) & ch_bit($past(cdr_idx))))
    else $error("channel read cleared a foreign end flag");

  sleep_end_a: assert property (conv_end_s |=> O_SLEEP ##1 (O_SLEEP || !$past(sleep_sel_r) || $past(start_cmd)))
    else $error("sleep not entered at conversion end");

  sleep_idle_a: assert property (idle_s |=> !O_SLEEP)
    else $error("sleep entered without a conversion");

  set_wins_a: assert property (store && rd_last |=> eoc_r[$past(I_EOC_CH)] && data_ready_flag_r)
    else $error("flag set lost against read clear");
endmodule

/* File: rtl/adcfl_wbs.sv */
module adcfl_wbs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // classic wishbone slave
  input wire logic i_cyc,
  input wire logic i_stb,
  input wire logic i_we,
  input wire logic [adcfl_pkg::ADCFL_AW-1:0] i_adr,
  input wire logic [3:0] i_sel,
  input wire logic [31:0] i_dat,
  output logic [31:0] o_dat,
  output logic o_ack,
  // accepted access
  adcfl_acc_if.slv acc_p
);
  import adcfl_pkg::*;

  logic ack_r;
  logic [31:0] dat_r;

  // one access per request, taken in the cycle before ack
  assign acc_p.acc = i_cyc & i_stb & ~ack_r;
  assign acc_p.we = i_we;
  assign acc_p.adr = i_adr;
  assign acc_p.wdat = i_dat;
  assign acc_p.wmask = {{8{i_sel[3]}}, {8{i_sel[2]}}, {8{i_sel[1]}}, {8{i_sel[0]}}};

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      ack_r <= 1'b0;
    else
      ack_r <= acc_p.acc;
  end

  // read data captured with the access
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      dat_r <= 32'h0000_0000;
    else if (acc_p.acc && !i_we)
      dat_r <= acc_p.rdat;
  end

  assign o_ack = ack_r;
  assign o_dat = dat_r;
endmodule

/* File: shared/adcfl_acc_if.sv */
// one accepted register access, from the bus slave to the register file
interface adcfl_acc_if #(
  parameter int unsigned AW = 8
);
  logic acc;
  logic we;
  logic [AW-1:0] adr;
  logic [31:0] wdat;
  logic [31:0] wmask;
  logic [31:0] rdat;
  modport slv (output acc, we, adr, wdat, wmask, input rdat);
  modport regs (input acc, we, adr, wdat, wmask, output rdat);
endinterface

/* File: shared/adcfl_pkg.sv */
package adcfl_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned ADCFL_NCH = 8;
  localparam int unsigned ADCFL_DW = 10;
  localparam int unsigned ADCFL_AW = 8;
  localparam int unsigned ADCFL_IRQ_W = 4;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADCFL_OFS_CTRL = 8'h00;
  localparam logic [7:0] ADCFL_OFS_MODE = 8'h04;
  localparam logic [7:0] ADCFL_OFS_CHEN = 8'h10;
  localparam logic [7:0] ADCFL_OFS_CHDIS = 8'h14;
  localparam logic [7:0] ADCFL_OFS_CHSR = 8'h18;
  localparam logic [7:0] ADCFL_OFS_STAT = 8'h1c;
  localparam logic [7:0] ADCFL_OFS_LAST = 8'h20;
  localparam logic [7:0] ADCFL_OFS_IST = 8'h2c;
  localparam logic [7:0] ADCFL_OFS_ICLR = 8'h30;
  localparam logic [7:0] ADCFL_OFS_IEN = 8'h34;
  localparam logic [7:0] ADCFL_OFS_CDR0 = 8'h40;
  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned ADCFL_CTRL_START = 1;
  localparam int unsigned ADCFL_MODE_SLEEP = 5;
  localparam int unsigned ADCFL_STAT_OVR_LSB = 8;
  localparam int unsigned ADCFL_STAT_DATA_READY_FLAG = 16;
  localparam int unsigned ADCFL_STAT_GOVR = 17;
  localparam int unsigned ADCFL_STAT_BUSY = 18;
  localparam int unsigned ADCFL_STAT_SLEEP = 19;
  localparam int unsigned ADCFL_LAST_CH_LSB = 12;
  localparam int unsigned ADCFL_IRQ_EOC = 0;
  localparam int unsigned ADCFL_IRQ_DATA_READY_FLAG = 1;
  localparam int unsigned ADCFL_IRQ_OVR = 2;
  localparam int unsigned ADCFL_IRQ_GOVR = 3;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic ADCFL_RST_SLEEP = 1'b0;
  localparam logic [3:0] ADCFL_RST_IEN = 4'h0;
  // ****************************************
  // conversion sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ADCFL_S_IDLE = 2'b00,
    ADCFL_S_CONV = 2'b01,
    ADCFL_S_SLEEP = 2'b10
  } adcfl_seq_e;
endpackage

/* File: tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adcfl_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, eoc = 1'b0, seq_end = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [2:0] eoc_ch = 3'h0;
  logic [9:0] eoc_dat = 10'h000;
  logic [31:0] rdat;
  logic [7:0] ch_en;
  logic ack, start, sleep, irq, st_seen;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h2719ae21;
  // ****************************************
  // reference model state
  // ****************************************
  logic [7:0] m_en = 8'h0, m_eoc = 8'h0, m_ovr = 8'h0;
  logic m_data_ready_flag = 0, m_govr = 0, m_busy = 0, m_sleep = 0, m_msel = 0, m_ist0 = 0, m_ien0 = 0;
  logic [9:0] m_cdr[8] = '{default: 10'h0};
  logic [9:0] m_ldat = 10'h0;
  logic [2:0] m_lch = 3'h0;

  // free-running clock
  always #2.5 clk = ~clk;

  adcfl_top dut (
    .I_REF_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_EOC(eoc), .I_EOC_CH(eoc_ch),
    .I_EOC_DATA(eoc_dat), .I_SEQ_END(seq_end), .O_START(start), .O_CH_EN(ch_en), .O_SLEEP(sleep),
    .O_IRQ(irq)
  );

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // expected read data, old values
  function automatic logic [31:0] model_rd(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      ADCFL_OFS_STAT: r = {12'h0, m_sleep, m_busy, m_govr, m_data_ready_flag, m_ovr, m_eoc};
      ADCFL_OFS_LAST: r = {17'h0, m_lch, 2'b00, m_ldat};
      ADCFL_OFS_CHSR: r = {24'h0, m_en};
      ADCFL_OFS_MODE: r = {26'h0, m_msel, 5'h0};
      default: if (a[7:5] == 3'b010 && a[1:0] == 2'b00) r = {22'h0, m_cdr[a[4:2]]};
    endcase
    return r;
  endfunction

  // flag update at the access edge, old enables
  task automatic model_step(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e,
                            input logic [2:0] c, input logic [9:0] v, input logic se);
    logic st;
    logic [7:0] clr;
    st = e && m_en[c];
    clr = 8'h0;
    if (!w && a[7:5] == 3'b010 && a[1:0] == 2'b00) clr[a[4:2]] = 1'b1;
    if (!w && a == ADCFL_OFS_LAST) clr = 8'hff;
    if (!w && a == ADCFL_OFS_STAT)
    begin
      m_ovr = 8'h0;
      m_govr = 1'b0;
    end
    if (st && m_eoc[c]) m_ovr[c] = 1'b1;
    if (st && m_data_ready_flag) m_govr = 1'b1;
    m_eoc = m_eoc & ~clr;
    if (!w && a == ADCFL_OFS_LAST) m_data_ready_flag = 1'b0;
    if (e && se && m_busy)
    begin
      m_busy = 1'b0;
      m_sleep = m_msel;
    end
    if (w)
      case (a)
        ADCFL_OFS_CHEN: m_en = m_en | d[7:0];
        ADCFL_OFS_CHDIS: m_en = m_en & ~d[7:0];
        ADCFL_OFS_MODE: {m_msel, m_sleep} = {d[5], m_sleep & d[5]};
        ADCFL_OFS_CTRL: if (d[1] && !m_busy) {m_busy, m_sleep} = 2'b10;
        ADCFL_OFS_IEN: m_ien0 = d[0];
        ADCFL_OFS_ICLR: if (d[0]) m_ist0 = 1'b0;
        default: ;
      endcase
    if (st)
    begin
      m_eoc[c] = 1'b1;
      m_data_ready_flag = 1'b1;
      m_cdr[c] = v;
      {m_lch, m_ldat, m_ist0} = {c, v, 1'b1};
    end
  endtask

  // one classic bus cycle, with an optional conversion end on the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e = 0,
                     input logic [2:0] c = 0, input logic [9:0] v = 0, input logic se = 0);
    logic [31:0] exp;
    int n;
    exp = model_rd(a);
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    {eoc, eoc_ch, eoc_dat, seq_end} <= {e, c, v, se};
    do
    begin
      @(posedge clk);
      {eoc, seq_end} <= 2'b00;
      n++;
    end while (ack !== 1'b1 && n < 20);
    check({31'h0, ack}, 32'h1);
    st_seen = start;
    {cyc, stb, we} <= 3'b000;
    if (!w) check(rdat, exp);
    model_step(w, a, d, e, c, v, se);
    check({24'h0, ch_en}, {24'h0, m_en});
  endtask

  task automatic chk_irq();
    @(posedge clk);
    check({31'h0, irq}, {31'h0, m_ist0 & m_ien0});
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      err_count++;
      results();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] r;
    logic [7:0] a;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    acc(0, ADCFL_OFS_STAT, 0);
    acc(0, ADCFL_OFS_LAST, 0);
    acc(1, ADCFL_OFS_CHEN, 32'h0f);
    // same-cycle collisions of events and reads
    acc(0, 8'h80, 0, 1, 1, 10'h155);
    acc(0, ADCFL_OFS_CDR0 + 8'h08, 0, 1, 1, 10'h2aa);
    acc(0, ADCFL_OFS_STAT, 0, 1, 1, 10'h011);
    acc(0, ADCFL_OFS_CDR0 + 8'h04, 0);
    // overrun set, end flag already read: status read must still clear it
    acc(0, ADCFL_OFS_STAT, 0, 1, 1, 10'h066);
    acc(0, ADCFL_OFS_LAST, 0, 1, 5, 10'h3ff);
    acc(0, ADCFL_OFS_STAT, 0, 1, 2, 10'h0f0);
    acc(1, ADCFL_OFS_CHDIS, 32'h08, 1, 2, 10'h10f);
    acc(0, ADCFL_OFS_STAT, 0);
    // random traffic against the model
    repeat (400)
    begin
      r = rnd();
      case (r[2:0])
        3'd0, 3'd1: a = ADCFL_OFS_STAT;
        3'd2: a = ADCFL_OFS_LAST;
        3'd3, 3'd4: a = ADCFL_OFS_CDR0 + {3'b000, r[10:8], 2'b00};
        3'd5: a = r[11] ? ADCFL_OFS_CHEN : ADCFL_OFS_CHDIS;
        3'd6: a = ADCFL_OFS_CHSR;
        default: a = 8'h80;
      endcase
      acc(r[2:0] == 3'd5, a, {24'h0, r[23:16]}, r[3] | r[4], r[7:5], r[31:22]);
    end
    // interrupt raise, mask, clear
    acc(1, ADCFL_OFS_CHEN, 32'hff);
    acc(1, ADCFL_OFS_ICLR, 32'hf);
    acc(1, ADCFL_OFS_IEN, 32'h1);
    chk_irq();
    acc(0, 8'h80, 0, 1, 0, 10'h2c3);
    chk_irq();
    acc(1, ADCFL_OFS_IEN, 32'h0);
    chk_irq();
    acc(1, ADCFL_OFS_IEN, 32'h1);
    chk_irq();
    acc(1, ADCFL_OFS_ICLR, 32'h1);
    chk_irq();
    // sleep only after the next conversion
    acc(1, ADCFL_OFS_MODE, 32'h20);
    repeat (10) @(posedge clk);
    check({31'h0, sleep}, 32'h0);
    acc(1, ADCFL_OFS_CTRL, 32'h2);
    check({31'h0, st_seen}, 32'h1);
    acc(0, ADCFL_OFS_STAT, 0);
    acc(0, 8'h80, 0, 1, 0, 10'h0aa, 1);
    check({31'h0, sleep}, {31'h0, m_sleep});
    acc(0, ADCFL_OFS_STAT, 0);
    acc(1, ADCFL_OFS_MODE, 32'h0);
    // sleep state leaves one edge after the deselect lands
    @(posedge clk);
    check({31'h0, sleep}, 32'h0);
    results();
  end
endmodule
